// [dv/cpu_core_model.sv]
// Behavioural CPU core: finishes instructions and keeps the software stack.
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
   input wire logic clock,
   input wire logic reset,
   input wire logic busy,
   input wire logic extra,
   input wire logic stack_push,
   input wire logic [7:0] push_status_low,
   input wire logic push_level_bit3,
   input wire logic stack_pop,
   output logic instr_last,
   output logic latency_extra,
   output logic [7:0] pop_status_low,
   output logic pop_level_bit3
);
   logic [8:0] stk [0:7];
   logic [2:0] sp;
   logic popped;
   logic live;
   logic [8:0] top;
   assign top = stk[sp - 3'h1];
   assign live = stack_pop && popped;
   // A long instruction holds off completion so no entry can cut it short.
   assign instr_last = !busy;
   assign latency_extra = extra && !busy;
   // Outside the second pop cycle the stack lines show junk.
   assign pop_status_low = live ? top[8:1] : ~top[8:1];
   assign pop_level_bit3 = live ? top[0] : ~top[0];
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         sp <= 3'h0;
         popped <= 1'b0;
      end else begin
         popped <= stack_pop && !popped;
         if (stack_push) begin
            stk[sp] <= {push_status_low, push_level_bit3};
            sp <= sp + 3'h1;
         end else if (live) begin
            sp <= sp - 3'h1;
         end
      end
   end
endmodule
`default_nettype wire

// [dv/pic_checker.sv]
// Concurrent checks on the core-side and bus-response ports of the controller.
`timescale 1ns/1ps
`default_nettype none
module pic_checker (
   input wire logic clock,
   input wire logic reset,
   input wire logic instr_last,
   input wire logic latency_extra,
   input wire logic irq_present,
   input wire logic return_from_handler,
   input wire logic power_save_active,
   input wire logic wake_request,
   input wire logic entry_save_pc,
   input wire logic entry_vector_load,
   input wire logic entry_routine_load,
   input wire logic stack_push,
   input wire logic stack_pop,
   input wire logic resume,
   input wire logic adc_conv_request,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   a_entry_steps:
      assert property (entry_save_pc |=> entry_vector_load ##1 entry_routine_load)
      else $error("entry steps out of order");
   a_save_cause:
      assert property (entry_save_pc |-> ($past(irq_present) && $past(instr_last) &&
         !$past(latency_extra)) || ($past(instr_last, 2) && $past(latency_extra, 2)))
      else $error("entry started without a finished instruction");
   a_push_pair:
      assert property (entry_save_pc == stack_push)
      else $error("stack push not with pc save");
   a_return_steps:
      assert property ($rose(return_from_handler) |=> stack_pop [*2] ##1 !stack_pop ##1 resume)
      else $error("return steps out of order");
   a_pop_cause:
      assert property ($rose(stack_pop) |-> $past(return_from_handler))
      else $error("pop without return");
   a_resume_once:
      assert property (resume |=> !resume && !stack_pop)
      else $error("resume longer than one cycle");
   a_wake_gate:
      assert property (wake_request |-> power_save_active)
      else $error("wake while running");
   a_wake_on_irq:
      assert property (power_save_active && irq_present |-> wake_request)
      else $error("no wake for a presentable request");
   a_adc_pulse:
      assert property (adc_conv_request |=> !adc_conv_request)
      else $error("conversion request not a pulse");
   a_read_once:
      assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read response repeated");
   c_entry: cover property (entry_routine_load);
   c_extra: cover property (latency_extra && instr_last ##2 entry_save_pc);
   c_resume: cover property (resume);
   c_wake: cover property (wake_request);
endmodule
`default_nettype wire

// [dv/priority_interrupt_controller_bench.sv]
// Self-checking bench for the priority interrupt controller.
`timescale 1ns/1ps
`default_nettype none
module priority_interrupt_controller_bench;
   typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [1:0] r;} row_s;
   logic clock = 1'b0, reset = 1'b1, clock_enable = 1'b1, s_axi_bready = 1'b1;
   logic s_axi_rready = 1'b1, trap_level_set = 1'b0, busy = 1'b1, extra = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, periph_request = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, adc_cnt = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [2:0] ext_request_pins = 3'h0;
   logic timed_mask_instruction = 1'b0, return_from_handler = 1'b0, power_save_active = 1'b0;
   logic [14:0] timed_mask_count = 15'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [2:0] vector_num;
   logic [7:0] pop_status_low, push_status_low;
   logic adc_conv_request, instr_last, latency_extra, pop_level_bit3, irq_present, wake_request;
   logic entry_save_pc, entry_vector_load, entry_routine_load, stack_push, push_level_bit3;
   logic stack_pop, resume;
   int n_fail = 0;
   int num_checks = 0;
   row_s rows [12] = '{
      '{1'b0, 8'h0c, 32'h0, 2'h0},
      '{1'b0, 8'h18, 32'h0, 2'h0},
      '{1'b1, 8'h14, 32'h5, 2'h0},
      '{1'b0, 8'h14, 32'h0, 2'h0},
      '{1'b0, 8'h10, 32'h0, 2'h0},
      '{1'b1, 8'h44, 32'h1, 2'h2},
      '{1'b0, 8'h44, 32'h0, 2'h2},
      '{1'b1, 8'h1c, 32'h8, 2'h0},
      '{1'b0, 8'h1c, 32'h0, 2'h0},
      '{1'b1, 8'h04, 32'hff, 2'h0},
      '{1'b1, 8'h08, 32'h69d9, 2'h0},
      '{1'b0, 8'h08, 32'h69d9, 2'h0}};
   priority_interrupt_controller i_dut (.clock, .reset, .clock_enable, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_request_pins,
      .periph_request, .adc_conv_request, .instr_last, .latency_extra, .timed_mask_instruction,
      .timed_mask_count, .return_from_handler, .pop_status_low, .pop_level_bit3,
      .trap_level_set, .power_save_active, .irq_present, .wake_request, .entry_save_pc,
      .entry_vector_load, .entry_routine_load, .stack_push, .push_status_low,
      .push_level_bit3, .vector_num, .stack_pop, .resume);
   cpu_core_model i_cpu (.clock, .reset, .busy, .extra, .stack_push, .push_status_low,
      .push_level_bit3, .stack_pop, .instr_last, .latency_extra, .pop_status_low,
      .pop_level_bit3);
   initial begin
      forever #20 clock = ~clock;
   end
   always @(posedge clock) begin
      if (adc_conv_request === 1'b1) adc_cnt <= adc_cnt + 32'h1;
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      forever begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      chk(s_axi_bresp, r);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      forever begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      chk(s_axi_rdata, e);
      chk(s_axi_rresp, r);
   endtask
   task automatic fire(input logic [7:0] v);
      periph_request <= v;
      @(posedge clock);
      periph_request <= 8'h00;
      @(posedge clock);
   endtask
   task automatic lvl(ref logic s, input logic e);
      repeat (3) @(posedge clock);
      chk(s, e);
   endtask
   task automatic wait_hi(ref logic s);
      for (int i = 0; i < 50 && s !== 1'b1; i++) @(posedge clock);
      chk(s, 1'b1);
   endtask
   task automatic mask(input logic [14:0] n);
      timed_mask_count <= n;
      timed_mask_instruction <= 1'b1;
      @(posedge clock);
      timed_mask_instruction <= 1'b0;
   endtask
   task automatic leave();
      return_from_handler <= 1'b1;
      @(posedge clock);
      return_from_handler <= 1'b0;
      wait_hi(resume);
   endtask
   initial begin
      repeat (20000) @(posedge clock);
      n_fail++;
      summarize();
   end
   initial begin
      repeat (3) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      foreach (rows[i]) begin
         if (rows[i].w) wr(rows[i].a, rows[i].d, rows[i].r);
         else rd(rows[i].a, rows[i].d, rows[i].r);
      end
      wr(8'h18, 32'ha0, 2'h0);
      fire(8'h08);
      lvl(irq_present, 1'b0);
      wr(8'h18, 32'h60, 2'h0);
      lvl(irq_present, 1'b1);
      chk(entry_save_pc, 1'b0);
      busy <= 1'b0;
      wait_hi(entry_routine_load);
      busy <= 1'b1;
      chk(vector_num, 3'h3);
      rd(8'h18, 32'h80, 2'h0);
      wr(8'h00, 32'h0, 2'h0);
      leave();
      rd(8'h18, 32'h60, 2'h0);
      wr(8'h18, 32'h0, 2'h0);
      wr(8'h0c, 32'h8000, 2'h0);
      extra <= 1'b1;
      busy <= 1'b0;
      fire(8'h02);
      wait_hi(entry_routine_load);
      busy <= 1'b1;
      rd(8'h18, 32'he0, 2'h0);
      wr(8'h18, 32'h0, 2'h0);
      rd(8'h18, 32'he0, 2'h0);
      fire(8'h10);
      lvl(irq_present, 1'b0);
      wr(8'h00, 32'h0, 2'h0);
      leave();
      rd(8'h18, 32'h0, 2'h0);
      wr(8'h0c, 32'h0, 2'h0);
      extra <= 1'b0;
      mask(15'h0040);
      fire(8'h02);
      lvl(irq_present, 1'b0);
      rd(8'h10, 32'h4000, 2'h0);
      fire(8'h04);
      lvl(irq_present, 1'b1);
      wr(8'h00, 32'h0, 2'h0);
      fire(8'h02);
      wr(8'h14, 32'h100, 2'h0);
      repeat (80) @(posedge clock);
      lvl(irq_present, 1'b0);
      wr(8'h14, 32'h0, 2'h0);
      lvl(irq_present, 1'b1);
      wr(8'h00, 32'h0, 2'h0);
      mask(15'h0008);
      fire(8'h02);
      repeat (10) @(posedge clock);
      lvl(irq_present, 1'b1);
      rd(8'h10, 32'h0, 2'h0);
      wr(8'h00, 32'h0, 2'h0);
      power_save_active <= 1'b1;
      fire(8'h20);
      lvl(wake_request, 1'b0);
      fire(8'h02);
      lvl(wake_request, 1'b1);
      wr(8'h00, 32'h0, 2'h0);
      power_save_active <= 1'b0;
      wr(8'h10, 32'h2, 2'h0);
      ext_request_pins <= 3'h3;
      repeat (6) @(posedge clock);
      rd(8'h00, 32'h1, 2'h0);
      ext_request_pins <= 3'h0;
      repeat (6) @(posedge clock);
      rd(8'h00, 32'h3, 2'h0);
      chk(adc_cnt, 32'h1);
      wr(8'h10, 32'h1, 2'h0);
      ext_request_pins <= 3'h1;
      repeat (6) @(posedge clock);
      ext_request_pins <= 3'h0;
      repeat (6) @(posedge clock);
      chk(adc_cnt, 32'h2);
      lvl(irq_present, 1'b1);
      trap_level_set <= 1'b1;
      @(posedge clock);
      trap_level_set <= 1'b0;
      lvl(irq_present, 1'b0);
      rd(8'h1c, 32'h8, 2'h0);
      wr(8'h0c, 32'h8000, 2'h0);
      reset <= 1'b1;
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      rd(8'h0c, 32'h0, 2'h0);
      rd(8'h1c, 32'h0, 2'h0);
      summarize();
   end
endmodule
bind priority_interrupt_controller pic_checker i_chk (.clock, .reset, .instr_last,
   .latency_extra, .irq_present, .return_from_handler, .power_save_active, .wake_request,
   .entry_save_pc, .entry_vector_load, .entry_routine_load, .stack_push, .stack_pop, .resume,
   .adc_conv_request, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// [rtl/priority_interrupt_controller.sv]
// Priority interrupt controller with timed masking, nesting control and AXI4-Lite registers.
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module priority_interrupt_controller (
   input wire logic clock,
   input wire logic reset,
   input wire logic clock_enable,
   // AXI4-Lite slave.
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Request sources.
   input wire logic [pic_pkg::EXT_PINS-1:0] ext_request_pins,
   input wire logic [pic_pkg::NUM_SRC-1:0] periph_request,
   output logic adc_conv_request,
   // CPU core side.
   input wire logic instr_last,
   input wire logic latency_extra,
   input wire logic timed_mask_instruction,
   input wire logic [pic_pkg::MASK_W-1:0] timed_mask_count,
   input wire logic return_from_handler,
   input wire logic [7:0] pop_status_low,
   input wire logic pop_level_bit3,
   input wire logic trap_level_set,
   input wire logic power_save_active,
   output logic irq_present,
   output logic wake_request,
   output logic entry_save_pc,
   output logic entry_vector_load,
   output logic entry_routine_load,
   output logic stack_push,
   output logic [7:0] push_status_low,
   output logic push_level_bit3,
   output logic [2:0] vector_num,
   output logic stack_pop,
   output logic resume
);
   typedef struct packed {
      logic [7:0] awaddr;
      logic aw_have;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic w_have;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [pic_pkg::NUM_SRC-1:0] flags;
      logic [pic_pkg::NUM_SRC-1:0] enables;
      logic [pic_pkg::NUM_SRC*pic_pkg::PRIO_W-1:0] prios;
      logic nest_dis;
      logic [pic_pkg::EXT_PINS-1:0] polarity;
      logic [pic_pkg::MASK_W-1:0] countdown;
      logic [7:0] status_low;
      logic level_bit3;
      pic_pkg::seq_e seq;
      logic [2:0] acc_src;
      logic [pic_pkg::PRIO_W-1:0] acc_prio;
      logic [pic_pkg::EXT_PINS-1:0] sync_one;
      logic [pic_pkg::EXT_PINS-1:0] sync_two;
      logic [pic_pkg::EXT_PINS-1:0] pin_prev;
      logic adc_req;
      logic [7:0] push_low;
      logic push_bit3;
   } state_s;

   state_s st_r;
   state_s st_nxt;

   // Merges written byte lanes into an old value.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // Priority of one source.
   function automatic logic [pic_pkg::PRIO_W-1:0] prio_of(
      input logic [pic_pkg::NUM_SRC*pic_pkg::PRIO_W-1:0] p, input int idx);
      return p[idx*pic_pkg::PRIO_W +: pic_pkg::PRIO_W];
   endfunction

   // Replaces the CPU priority field inside a status low byte.
   function automatic logic [7:0] with_field(input logic [7:0] status,
                                             input logic [pic_pkg::PRIO_W-1:0] field);
      logic [7:0] res;
      res = status;
      res[pic_pkg::FIELD_HI:pic_pkg::FIELD_LO] = field;
      return res;
   endfunction

   logic [pic_pkg::NUM_SRC-1:0] pending;
   logic [pic_pkg::PRIO_W-1:0] best_prio;
   logic [2:0] best_src;
   logic any_wake;
   logic timed_masking;
   logic [pic_pkg::PRIO_W-1:0] cpu_field;
   logic [pic_pkg::EXT_PINS-1:0] edge_evt;
   logic do_write;
   logic [31:0] wr_val;
   logic [31:0] rd_val;
   logic rd_ok;
   logic wr_ok;

   assign cpu_field = st_r.status_low[pic_pkg::FIELD_HI:pic_pkg::FIELD_LO];
   assign timed_masking = st_r.countdown != '0;

   always_comb begin
      best_prio = pic_pkg::PRIO_NONE;
      best_src = '0;
      any_wake = 1'b0;
      for (int i = 0; i < pic_pkg::NUM_SRC; i++) begin
         // A priority 0 source is treated as disabled.
         pending[i] = st_r.flags[i] && st_r.enables[i]
                      && prio_of(st_r.prios, i) != pic_pkg::PRIO_NONE;
         if (pending[i]) begin
            any_wake = 1'b1;
         end
         // Ties go to the lowest source number.
         if (pending[i] && prio_of(st_r.prios, i) > best_prio) begin
            best_prio = prio_of(st_r.prios, i);
            best_src = 3'(i);
         end
      end
   end

   // Presented only above the current field, with bit 3 clear and no timed mask below 7.
   assign irq_present = best_prio > cpu_field && !st_r.level_bit3
                        && (!timed_masking || best_prio == pic_pkg::PRIO_TOP);
   assign wake_request = power_save_active && any_wake;

   always_comb begin
      for (int i = 0; i < pic_pkg::EXT_PINS; i++) begin
         // Polarity one selects the falling edge.
         // The previous sample starts at zero, so a pin held high at reset shows a rising edge.
         edge_evt[i] = st_r.polarity[i] ? (st_r.pin_prev[i] && !st_r.sync_two[i])
                                        : (!st_r.pin_prev[i] && st_r.sync_two[i]);
      end
   end

   // Read data is decoded from the address while the request is being taken.
   always_comb begin
      rd_ok = 1'b1;
      rd_val = '0;
      case (s_axi_araddr)
         pic_pkg::OFF_FLAGS: rd_val[pic_pkg::NUM_SRC-1:0] = st_r.flags;
         pic_pkg::OFF_ENABLES: rd_val[pic_pkg::NUM_SRC-1:0] = st_r.enables;
         pic_pkg::OFF_PRIOS: rd_val[pic_pkg::NUM_SRC*pic_pkg::PRIO_W-1:0] = st_r.prios;
         pic_pkg::OFF_CTRL_ONE: rd_val[pic_pkg::BIT_NEST_DIS] = st_r.nest_dis;
         pic_pkg::OFF_CTRL_TWO: begin
            rd_val[pic_pkg::BIT_MASK_STAT] = timed_masking;
            rd_val[pic_pkg::EXT_PINS-1:0] = st_r.polarity;
         end
         pic_pkg::OFF_COUNTDOWN: rd_val[pic_pkg::MASK_W-1:0] = st_r.countdown;
         pic_pkg::OFF_STATUS: rd_val[7:0] = st_r.status_low;
         pic_pkg::OFF_CORE_CTRL: rd_val[pic_pkg::BIT_LEVEL3] = st_r.level_bit3;
         pic_pkg::OFF_VECTOR: begin
            rd_val[2:0] = best_src;
            rd_val[pic_pkg::VEC_PEND_BIT] = irq_present;
         end
         default: rd_ok = 1'b0;
      endcase
   end

   always_comb begin
      case (st_r.awaddr)
         pic_pkg::OFF_FLAGS, pic_pkg::OFF_ENABLES, pic_pkg::OFF_PRIOS,
         pic_pkg::OFF_CTRL_ONE, pic_pkg::OFF_CTRL_TWO, pic_pkg::OFF_COUNTDOWN,
         pic_pkg::OFF_STATUS, pic_pkg::OFF_CORE_CTRL, pic_pkg::OFF_VECTOR: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   // Readies drop while the clock is disabled, so no beat is taken without being stored.
   assign s_axi_awready = clock_enable && !st_r.aw_have && !st_r.bvalid;
   assign s_axi_wready = clock_enable && !st_r.w_have && !st_r.bvalid;
   assign s_axi_arready = clock_enable && !st_r.rvalid;
   assign s_axi_bvalid = st_r.bvalid;
   assign s_axi_bresp = st_r.bresp;
   assign s_axi_rvalid = st_r.rvalid;
   assign s_axi_rdata = st_r.rdata;
   assign s_axi_rresp = st_r.rresp;
   assign do_write = st_r.aw_have && st_r.w_have && !st_r.bvalid;

   always_comb begin
      st_nxt = st_r;
      wr_val = '0;
      // Bus channels.
      if (s_axi_awvalid && s_axi_awready) begin
         st_nxt.awaddr = s_axi_awaddr;
         st_nxt.aw_have = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         st_nxt.wdata = s_axi_wdata;
         st_nxt.wstrb = s_axi_wstrb;
         st_nxt.w_have = 1'b1;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         st_nxt.bvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rdata = rd_val;
         st_nxt.rresp = rd_ok ? pic_pkg::RESP_OKAY : pic_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         st_nxt.rvalid = 1'b0;
      end
      // Countdown runs every enabled cycle, stalls included.
      if (timed_masking) begin
         st_nxt.countdown = st_r.countdown - 1'b1;
      end
      if (do_write) begin
         st_nxt.aw_have = 1'b0;
         st_nxt.w_have = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = wr_ok ? pic_pkg::RESP_OKAY : pic_pkg::RESP_SLVERR;
         case (st_r.awaddr)
            pic_pkg::OFF_FLAGS: begin
               wr_val = merge({24'h0, st_r.flags}, st_r.wdata, st_r.wstrb);
               st_nxt.flags = wr_val[pic_pkg::NUM_SRC-1:0];
            end
            pic_pkg::OFF_ENABLES: begin
               wr_val = merge({24'h0, st_r.enables}, st_r.wdata, st_r.wstrb);
               st_nxt.enables = wr_val[pic_pkg::NUM_SRC-1:0];
            end
            pic_pkg::OFF_PRIOS: begin
               wr_val = merge({8'h0, st_r.prios}, st_r.wdata, st_r.wstrb);
               st_nxt.prios = wr_val[pic_pkg::NUM_SRC*pic_pkg::PRIO_W-1:0];
            end
            pic_pkg::OFF_CTRL_ONE: begin
               wr_val = merge({16'h0, st_r.nest_dis, 15'h0}, st_r.wdata, st_r.wstrb);
               st_nxt.nest_dis = wr_val[pic_pkg::BIT_NEST_DIS];
            end
            pic_pkg::OFF_CTRL_TWO: begin
               wr_val = merge({29'h0, st_r.polarity}, st_r.wdata, st_r.wstrb);
               st_nxt.polarity = wr_val[pic_pkg::EXT_PINS-1:0];
            end
            pic_pkg::OFF_COUNTDOWN: begin
               wr_val = merge({17'h0, st_r.countdown}, st_r.wdata, st_r.wstrb);
               // Only an active mask may be changed; a zero countdown stays zero.
               if (timed_masking) begin
                  st_nxt.countdown = wr_val[pic_pkg::MASK_W-1:0];
               end
            end
            pic_pkg::OFF_STATUS: begin
               wr_val = merge({24'h0, st_r.status_low}, st_r.wdata, st_r.wstrb);
               st_nxt.status_low = wr_val[7:0];
               if (st_r.nest_dis) begin
                  st_nxt.status_low = with_field(st_nxt.status_low, cpu_field);
               end
            end
            default: wr_val = '0;
         endcase
      end
      if (timed_mask_instruction) begin
         st_nxt.countdown = (timed_mask_count > pic_pkg::MASK_MAX) ? pic_pkg::MASK_MAX
                                                                   : timed_mask_count;
      end
      // Pin synchronisers and edge capture.
      st_nxt.sync_one = ext_request_pins;
      st_nxt.sync_two = st_r.sync_one;
      st_nxt.pin_prev = st_r.sync_two;
      st_nxt.adc_req = edge_evt[0];
      // Hardware sets win over a software clear in the same cycle.
      st_nxt.flags = st_nxt.flags | periph_request
                     | {{(pic_pkg::NUM_SRC-pic_pkg::EXT_PINS){1'b0}}, edge_evt};
      // Only reset or a return pop clears level bit 3; software cannot.
      if (trap_level_set) begin
         st_nxt.level_bit3 = 1'b1;
      end
      // Entry and return sequencing.
      case (st_r.seq)
         pic_pkg::SEQ_IDLE: begin
            // A return takes precedence because the running handler is already finishing.
            if (return_from_handler) begin
               st_nxt.seq = pic_pkg::SEQ_RET_ONE;
            end else if (irq_present && instr_last) begin
               st_nxt.acc_src = best_src;
               st_nxt.acc_prio = best_prio;
               st_nxt.push_low = st_r.status_low;
               st_nxt.push_bit3 = st_r.level_bit3;
               st_nxt.seq = latency_extra ? pic_pkg::SEQ_EXTRA
                                          : pic_pkg::SEQ_SAVE;
            end
         end
         pic_pkg::SEQ_EXTRA: st_nxt.seq = pic_pkg::SEQ_SAVE;
         pic_pkg::SEQ_SAVE: st_nxt.seq = pic_pkg::SEQ_VECTOR;
         pic_pkg::SEQ_VECTOR: begin
            // The entry update overrides a software field write in the same cycle.
            st_nxt.status_low = with_field(st_nxt.status_low,
               st_r.nest_dis ? pic_pkg::PRIO_TOP : st_r.acc_prio);
            st_nxt.seq = pic_pkg::SEQ_ROUTINE;
         end
         pic_pkg::SEQ_ROUTINE: st_nxt.seq = pic_pkg::SEQ_IDLE;
         pic_pkg::SEQ_RET_ONE: st_nxt.seq = pic_pkg::SEQ_RET_TWO;
         pic_pkg::SEQ_RET_TWO: begin
            st_nxt.status_low = pop_status_low;
            st_nxt.level_bit3 = pop_level_bit3;
            st_nxt.seq = pic_pkg::SEQ_RET_FETCH;
         end
         pic_pkg::SEQ_RET_FETCH: st_nxt.seq = pic_pkg::SEQ_RET_RESUME;
         pic_pkg::SEQ_RET_RESUME: st_nxt.seq = pic_pkg::SEQ_IDLE;
         default: st_nxt.seq = pic_pkg::SEQ_IDLE;
      endcase
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         st_r <= '0;
      end else if (clock_enable) begin
         st_r <= st_nxt;
      end
   end

   // Sequencing strobes decode straight from the state and stand one cycle each, except stack_pop, which stands two.
   assign adc_conv_request = st_r.adc_req;
   assign entry_save_pc = st_r.seq == pic_pkg::SEQ_SAVE;
   assign stack_push = st_r.seq == pic_pkg::SEQ_SAVE;
   assign entry_vector_load = st_r.seq == pic_pkg::SEQ_VECTOR;
   assign entry_routine_load = st_r.seq == pic_pkg::SEQ_ROUTINE;
   assign push_status_low = st_r.push_low;
   assign push_level_bit3 = st_r.push_bit3;
   assign vector_num = st_r.acc_src;
   assign stack_pop = st_r.seq == pic_pkg::SEQ_RET_ONE || st_r.seq == pic_pkg::SEQ_RET_TWO;
   assign resume = st_r.seq == pic_pkg::SEQ_RET_RESUME;
endmodule
`default_nettype wire

// [shared/pic_pkg.sv]
// Constants and types shared by the priority interrupt controller.
package pic_pkg;
   localparam int NUM_SRC = 8;
   localparam int PRIO_W = 3;
   localparam int EXT_PINS = 3;
   localparam int MASK_W = 15;
   localparam logic [MASK_W-1:0] MASK_MAX = 15'h4000;
   localparam logic [PRIO_W-1:0] PRIO_TOP = 3'h7;
   localparam logic [PRIO_W-1:0] PRIO_NONE = 3'h0;
   // Register byte offsets.
   localparam logic [7:0] OFF_FLAGS = 8'h00;
   localparam logic [7:0] OFF_ENABLES = 8'h04;
   localparam logic [7:0] OFF_PRIOS = 8'h08;
   localparam logic [7:0] OFF_CTRL_ONE = 8'h0c;
   localparam logic [7:0] OFF_CTRL_TWO = 8'h10;
   localparam logic [7:0] OFF_COUNTDOWN = 8'h14;
   localparam logic [7:0] OFF_STATUS = 8'h18;
   localparam logic [7:0] OFF_CORE_CTRL = 8'h1c;
   localparam logic [7:0] OFF_VECTOR = 8'h20;
   // Field positions.
   localparam int BIT_NEST_DIS = 15;
   localparam int BIT_MASK_STAT = 14;
   localparam int BIT_LEVEL3 = 3;
   localparam int FIELD_LO = 5;
   localparam int FIELD_HI = 7;
   localparam int VEC_PEND_BIT = 8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [3:0] {
      SEQ_IDLE = 4'h0,
      SEQ_EXTRA = 4'h1,
      SEQ_SAVE = 4'h2,
      SEQ_VECTOR = 4'h3,
      SEQ_ROUTINE = 4'h4,
      SEQ_RET_ONE = 4'h5,
      SEQ_RET_TWO = 4'h6,
      SEQ_RET_FETCH = 4'h7,
      SEQ_RET_RESUME = 4'h8
   } seq_e;
endpackage
